// >>> osm_cfg.svh
// offsets, source and drive codes and timing counts of the clock block
`ifndef OSM_CFG_SVH
`define OSM_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OSM_ADDR_CTRL        12'h000
`define OSM_ADDR_STAT        12'h004
`define OSM_ADDR_BDCR        12'h008
`define OSM_ADDR_CIR         12'h00C

// ----------------------------------------------------------------
// root clock source codes
// ----------------------------------------------------------------
`define OSM_SRC_INT_FAST     2'h0
`define OSM_SRC_INT_LP       2'h1
`define OSM_SRC_EXT_FAST     2'h2
`define OSM_SRC_PLL          2'h3

// ----------------------------------------------------------------
// slow crystal drive level codes
// ----------------------------------------------------------------
`define OSM_DRV_LOW          2'h0
`define OSM_DRV_MED_LOW      2'h2
`define OSM_DRV_MED_HIGH     2'h1
`define OSM_DRV_HIGH         2'h3

// ----------------------------------------------------------------
// timing: clock period and derived cycle counts
// ----------------------------------------------------------------
`define OSM_CLK_PERIOD_NS    20
`define OSM_FAST_FAIL_NS     1000
`define OSM_FAST_FAIL_CYC    (`OSM_FAST_FAIL_NS / `OSM_CLK_PERIOD_NS)
`define OSM_SLOW_FAIL_NS     122070
`define OSM_SLOW_FAIL_CYC    (`OSM_SLOW_FAIL_NS / `OSM_CLK_PERIOD_NS)
`define OSM_FAST_START_EDGES 2048
`define OSM_SLOW_START_EDGES 1024
`define OSM_GATE_CYC         4

`endif

// >>> osm_clock_ctrl.sv
// oscillator enable, ready, bypass, root select and failure monitors
//
// Summary of operation
// - root clock from four selectable sources
// - internal 32 kHz oscillator feeds watchdog, calendar
// - every source enabled or stopped on its own, unless in use
// - fast bypass needs bypass and enable bits
// - fast external unusable until ready flag set
// - ready flags raise interrupt when enabled
// - fast crystal stoppable only when not in use
// - slow external enable bit in backup register
// - drive field: 00 low, 10, 01, 11 high
// - slow output withheld until its ready flag
// - slow bypass in all modes, max 1 MHz
// - slow bypass needs bypass and enable bits
// - two failure monitors, enabled independently
// - fast monitor runs only after startup, while on
// - fast failure moves root to internal fast if fast feeds it or is requested
// - fast failure: disable, timer break, nmi
// - fast failure disables pll using it
// - slow failure wakes except in battery mode
// - slow monitor never disabled by hardware
//
// Register access over APB and the placing of the registers were decided locally.
`include "osm_cfg.svh"
`default_nettype none
module osm_clock_ctrl
  import osm_pkg::*;
#(
  parameter logic [11:0] FAST_START_EDGES = 12'(`OSM_FAST_START_EDGES),
  parameter logic [11:0] SLOW_START_EDGES = 12'(`OSM_SLOW_START_EDGES),
  parameter logic [15:0] FAST_FAIL_CYC    = 16'(`OSM_FAST_FAIL_CYC),
  parameter logic [15:0] SLOW_FAIL_CYC    = 16'(`OSM_SLOW_FAIL_CYC),
  parameter logic [3:0]  GATE_CYC         = 4'(`OSM_GATE_CYC)
)(
  input  wire logic         i_clk,                  // system clock
  input  wire logic         i_arst_n,               // async reset
  input  wire osm_apb_req_t i_apb,                  // apb request
  output logic              o_pready,               // apb ready
  output logic [31:0]       o_prdata,               // apb read data
  output logic              o_pslverr,              // apb error
  input  wire logic         i_fast_osc_input_pin,   // fast osc clock
  input  wire logic         i_slow_osc_input_pin,   // slow osc clock
  input  wire logic         i_pll_lock,             // pll locked
  input  wire logic         i_battery_mode,         // battery supply only
  input  wire logic         i_wdg_run,              // watchdog running
  output logic              o_internal_fast_osc_en, // internal fast on
  output logic              o_internal_lp_osc_en,   // internal low-power on
  output logic              o_internal_slow_osc_en, // internal slow on
  output logic              o_fast_ext_enable,      // fast ext osc on
  output logic              o_fast_ext_bypass,      // fast bypass mode
  output logic              o_fast_ext_gate,        // fast clock released
  output logic              o_slow_ext_enable,      // slow ext osc on
  output logic              o_slow_ext_bypass,      // slow bypass mode
  output logic [1:0]        o_slow_ext_drive_level, // crystal drive
  output logic              o_slow_ext_gate,        // slow clock released
  output logic [1:0]        o_calendar_clock_select,// calendar source
  output logic              o_pll_enable,           // pll on
  output logic              o_pll_src,              // 1: pll from fast ext
  output logic [1:0]        o_core_clock_root_sel,  // root mux select
  output logic              o_core_clock_root_gate, // root clock gate
  output logic              o_timer_break,          // break pulse
  output logic              o_fast_ext_fail_irq,    // nmi level
  output logic              o_ready_irq,            // ready interrupt
  output logic              o_slow_fail_wake        // wakeup request
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // source usable as root
  function automatic logic src_ready(input logic [1:0] sel,
                                     input osm_state_t st);
    logic r;
    r = 1'b0;
    unique case (sel)
      `OSM_SRC_INT_FAST: r = st.int_fast_en;
      `OSM_SRC_INT_LP:   r = st.int_lp_en;
      `OSM_SRC_EXT_FAST: r = st.fast_rdy;
      `OSM_SRC_PLL:      r = st.pll_en & st.pll_sync[1];
    endcase
    return r;
  endfunction

  // fast external feeding root directly or through pll
  function automatic logic fast_feeds(input logic [1:0] sel,
                                      input logic psrc);
    return (sel == `OSM_SRC_EXT_FAST) | ((sel == `OSM_SRC_PLL) & psrc);
  endfunction

  // mapped address check
  function automatic logic addr_ok(input logic [11:0] a);
    return (a == `OSM_ADDR_CTRL) | (a == `OSM_ADDR_STAT) |
           (a == `OSM_ADDR_BDCR) | (a == `OSM_ADDR_CIR);
  endfunction

  // read word assembly
  function automatic logic [31:0] rd_word(input logic [11:0] a,
                                          input osm_state_t st);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      `OSM_ADDR_CTRL: d = {22'h0, st.root_req, st.fast_css_en, st.pll_src,
                           st.pll_en, st.fast_byp, st.fast_en,
                           st.int_slow_en, st.int_lp_en, st.int_fast_en};
      `OSM_ADDR_STAT: d = {26'h0, st.root_act, st.sw != SW_IDLE,
                           st.pll_sync[1], st.slow_rdy, st.fast_rdy};
      `OSM_ADDR_BDCR: d = {20'h0, st.slow_fail, st.slow_css_en, st.cal_sel,
                           3'h0, st.drive, st.slow_byp, st.slow_rdy,
                           st.slow_en};
      `OSM_ADDR_CIR:  d = {22'h0, st.slow_rdy_ie, st.fast_rdy_ie, 5'h0,
                           st.fast_fail_f, st.slow_rdy_f, st.fast_rdy_f};
      default:        d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // state and combinational next state
  // ----------------------------------------------------------------
  osm_state_t s_ff;
  osm_state_t nxt_s;
  logic       fedge, sedge, ffail, sfail, wr, fast_busy;

  // edge detect and failure decode, read by next-state logic and the assertions
  always_comb begin
    fedge     = s_ff.fsync[1] & ~s_ff.fsync[2];
    sedge     = s_ff.ssync[1] & ~s_ff.ssync[2];
    // fast monitor armed only after startup
    // a stopped oscillator disarms at once, so one break per failure
    ffail     = s_ff.fast_css_en & s_ff.fast_en & s_ff.fast_rdy & ~fedge &
                (s_ff.fwd == FAST_FAIL_CYC);
    // slow monitor independent of fast one
    sfail     = s_ff.slow_css_en & s_ff.slow_rdy & ~sedge &
                (s_ff.swd == SLOW_FAIL_CYC);
    wr        = i_apb.psel & i_apb.penable & s_ff.pready & i_apb.pwrite &
                addr_ok(i_apb.paddr);
    fast_busy = fast_feeds(s_ff.root_act, s_ff.pll_src) |
                fast_feeds(s_ff.root_req, s_ff.pll_src);
  end

  always_comb begin
    nxt_s = s_ff;
    // two-stage synchronisers, third stage for edge detect
    nxt_s.fsync    = {s_ff.fsync[1:0], i_fast_osc_input_pin};
    nxt_s.ssync    = {s_ff.ssync[1:0], i_slow_osc_input_pin};
    nxt_s.pll_sync = {s_ff.pll_sync[0], i_pll_lock};
    nxt_s.bat_sync = {s_ff.bat_sync[0], i_battery_mode};
    nxt_s.wdg_sync = {s_ff.wdg_sync[0], i_wdg_run};

    // apb: data captured in setup, answered in first access cycle
    nxt_s.pready = i_apb.psel & ~i_apb.penable;
    if (i_apb.psel & ~i_apb.penable) begin
      nxt_s.prdata  = rd_word(i_apb.paddr, s_ff);
      nxt_s.pslverr = ~addr_ok(i_apb.paddr);
    end

    // software writes
    if (wr) begin
      unique case (i_apb.paddr)
        `OSM_ADDR_CTRL: begin
          // each source switched on its own, unless in use
          nxt_s.int_fast_en = i_apb.pwdata[0] |
                              (s_ff.root_act == `OSM_SRC_INT_FAST);
          nxt_s.int_lp_en   = i_apb.pwdata[1] |
                              (s_ff.root_act == `OSM_SRC_INT_LP);
          nxt_s.int_slow_en = i_apb.pwdata[2];
          // fast crystal stop ignored while it feeds root
          nxt_s.fast_en     = i_apb.pwdata[3] | fast_busy;
          // bypass with enable gives bypass mode
          nxt_s.fast_byp    = i_apb.pwdata[4];
          nxt_s.pll_en      = i_apb.pwdata[5] |
                              (s_ff.root_act == `OSM_SRC_PLL);
          nxt_s.pll_src     = i_apb.pwdata[6];
          nxt_s.fast_css_en = i_apb.pwdata[7];
          // root request from any of four sources
          nxt_s.root_req    = i_apb.pwdata[9:8];
        end
        `OSM_ADDR_BDCR: begin
          // slow external enable in backup register
          nxt_s.slow_en     = i_apb.pwdata[0];
          // bypass kept in every power mode
          nxt_s.slow_byp    = i_apb.pwdata[2];
          // drive code passed unchanged to the oscillator
          nxt_s.drive       = i_apb.pwdata[4:3];
          nxt_s.cal_sel     = i_apb.pwdata[9:8];
          nxt_s.slow_css_en = i_apb.pwdata[10];
          nxt_s.slow_fail   = s_ff.slow_fail & ~i_apb.pwdata[11];
        end
        `OSM_ADDR_CIR: begin
          nxt_s.fast_rdy_f  = s_ff.fast_rdy_f & ~i_apb.pwdata[0];
          nxt_s.slow_rdy_f  = s_ff.slow_rdy_f & ~i_apb.pwdata[1];
          nxt_s.fast_fail_f = s_ff.fast_fail_f & ~i_apb.pwdata[2];
          nxt_s.fast_rdy_ie = i_apb.pwdata[8];
          nxt_s.slow_rdy_ie = i_apb.pwdata[9];
        end
        default: ;
      endcase
    end

    // fast ready after counted stable edges
    if (!s_ff.fast_en) begin
      nxt_s.fast_cnt = 12'h000;
      nxt_s.fast_rdy = 1'b0;
    end else if (!s_ff.fast_rdy && fedge) begin
      nxt_s.fast_cnt = s_ff.fast_cnt + 12'h001;
      nxt_s.fast_rdy = (s_ff.fast_cnt == FAST_START_EDGES - 12'h001);
    end
    // slow ready after counted stable edges
    if (!s_ff.slow_en) begin
      nxt_s.slow_cnt = 12'h000;
      nxt_s.slow_rdy = 1'b0;
    end else if (!s_ff.slow_rdy && sedge) begin
      nxt_s.slow_cnt = s_ff.slow_cnt + 12'h001;
      nxt_s.slow_rdy = (s_ff.slow_cnt == SLOW_START_EDGES - 12'h001);
    end

    // missing-edge counters, held clear while disarmed
    if (!(s_ff.fast_css_en & s_ff.fast_en & s_ff.fast_rdy) || fedge)
      nxt_s.fwd = 16'h0000;
    else if (s_ff.fwd != FAST_FAIL_CYC)
      nxt_s.fwd = s_ff.fwd + 16'h0001;
    if (!(s_ff.slow_css_en & s_ff.slow_rdy) || sedge)
      nxt_s.swd = 16'h0000;
    else if (s_ff.swd != SLOW_FAIL_CYC)
      nxt_s.swd = s_ff.swd + 16'h0001;

    // failure stops oscillator and sends break
    nxt_s.brk = ffail;
    if (ffail) begin
      nxt_s.fast_en = 1'b0;
      // pll fed by the failed oscillator goes off
      if (s_ff.pll_src)
        nxt_s.pll_en = 1'b0;
      // fall back to internal fast oscillator
      if (fast_busy) begin
        nxt_s.root_req    = `OSM_SRC_INT_FAST;
        nxt_s.int_fast_en = 1'b1;
      end
    end

    // nmi flag sticky, set wins over clear
    nxt_s.fast_fail_f = nxt_s.fast_fail_f | ffail;
    // ready rise sets flag, set wins over clear
    nxt_s.fast_rdy_f = nxt_s.fast_rdy_f | (~s_ff.fast_rdy & nxt_s.fast_rdy);
    nxt_s.slow_rdy_f = nxt_s.slow_rdy_f | (~s_ff.slow_rdy & nxt_s.slow_rdy);
    nxt_s.rdy_irq = (nxt_s.fast_rdy_f & nxt_s.fast_rdy_ie) |
                    (nxt_s.slow_rdy_f & nxt_s.slow_rdy_ie);
    // hardware never clears slow monitor enable
    nxt_s.slow_fail = nxt_s.slow_fail | sfail;
    // wake unless on battery, flag kept for later
    nxt_s.wake = nxt_s.slow_fail & ~s_ff.bat_sync[1];
    // internal slow on for software or watchdog
    nxt_s.int_slow_on = nxt_s.int_slow_en | s_ff.wdg_sync[1];

    // root mux only changes while the root is gated off
    unique case (s_ff.sw)
      SW_IDLE: begin
        nxt_s.gate = 1'b1;
        if (s_ff.root_req != s_ff.root_act &&
            src_ready(s_ff.root_req, s_ff)) begin
          nxt_s.sw   = SW_GATE;
          nxt_s.gate = 1'b0;
          nxt_s.gcnt = GATE_CYC;
        end
      end
      SW_GATE: begin
        if (s_ff.gcnt != 4'h0) begin
          nxt_s.gcnt = s_ff.gcnt - 4'h1;
        end else if (src_ready(s_ff.root_req, s_ff)) begin
          nxt_s.root_act = s_ff.root_req;
          nxt_s.sw       = SW_OPEN;
          nxt_s.gcnt     = GATE_CYC;
        end
      end
      SW_OPEN: begin
        if (s_ff.gcnt != 4'h0) begin
          nxt_s.gcnt = s_ff.gcnt - 4'h1;
        end else begin
          nxt_s.gate = 1'b1;
          nxt_s.sw   = SW_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset: internal fast oscillator runs and drives the root
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_ff             <= '0;
      s_ff.sw          <= SW_IDLE;
      s_ff.int_fast_en <= 1'b1;
      s_ff.gate        <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output taken straight from the state register
  assign o_pready               = s_ff.pready;
  assign o_prdata               = s_ff.prdata;
  assign o_pslverr              = s_ff.pslverr;
  assign o_internal_fast_osc_en = s_ff.int_fast_en;
  assign o_internal_lp_osc_en   = s_ff.int_lp_en;
  assign o_internal_slow_osc_en = s_ff.int_slow_on;
  assign o_fast_ext_enable      = s_ff.fast_en;
  assign o_fast_ext_bypass      = s_ff.fast_byp;
  assign o_fast_ext_gate        = s_ff.fast_rdy;
  assign o_slow_ext_enable      = s_ff.slow_en;
  assign o_slow_ext_bypass      = s_ff.slow_byp;
  assign o_slow_ext_drive_level = s_ff.drive;
  assign o_slow_ext_gate        = s_ff.slow_rdy;
  assign o_calendar_clock_select = s_ff.cal_sel;
  assign o_pll_enable           = s_ff.pll_en;
  assign o_pll_src              = s_ff.pll_src;
  assign o_core_clock_root_sel  = s_ff.root_act;
  assign o_core_clock_root_gate = s_ff.gate;
  assign o_timer_break          = s_ff.brk;
  assign o_fast_ext_fail_irq    = s_ff.fast_fail_f;
  assign o_ready_irq            = s_ff.rdy_irq;
  assign o_slow_fail_wake       = s_ff.wake;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  logic clr_nmi;
  assign clr_nmi = wr & (i_apb.paddr == `OSM_ADDR_CIR) & i_apb.pwdata[2];

  fail_fallback_a: assert property (
    ffail && fast_busy |=> o_internal_fast_osc_en &&
    s_ff.root_req == `OSM_SRC_INT_FAST)
    else $error("root not sent to internal fast after failure");
  fail_actions_a: assert property (
    ffail |=> !o_fast_ext_enable && o_timer_break && o_fast_ext_fail_irq)
    else $error("fast failure actions missing");
  pll_kill_a: assert property (
    ffail && o_pll_src |=> !o_pll_enable)
    else $error("pll left on after reference failure");
  nmi_hold_a: assert property (
    o_fast_ext_fail_irq && !clr_nmi |=> o_fast_ext_fail_irq)
    else $error("nmi dropped without software clear");
  ext_ready_a: assert property (
    $changed(o_core_clock_root_sel) &&
    o_core_clock_root_sel == `OSM_SRC_EXT_FAST |-> o_fast_ext_gate)
    else $error("fast external selected before ready");
  gated_swap_a: assert property (
    $changed(o_core_clock_root_sel) |-> !o_core_clock_root_gate &&
    !$past(o_core_clock_root_gate) ##1 !o_core_clock_root_gate[*2])
    else $error("root select changed while clock ungated");
  monitor_arm_a: assert property (
    ffail |-> o_fast_ext_gate && !fedge && s_ff.fast_css_en)
    else $error("fast monitor fired while disarmed");
  slow_css_keep_a: assert property (
    s_ff.slow_css_en && !(wr && i_apb.paddr == `OSM_ADDR_BDCR)
    |=> s_ff.slow_css_en)
    else $error("slow monitor enable cleared by hardware");
  slow_wake_a: assert property (
    sfail && !s_ff.bat_sync[1] |=> o_slow_fail_wake && s_ff.slow_fail)
    else $error("slow failure gave no wake");
  ready_irq_a: assert property (
    $rose(o_fast_ext_gate) && s_ff.fast_rdy_ie |-> o_ready_irq)
    else $error("ready interrupt missing");
  slow_release_a: assert property (
    !o_slow_ext_enable |=> !o_slow_ext_gate)
    else $error("slow clock released while stopped");

  fallback_c:  cover property (ffail && fast_busy ##[1:20]
                               o_core_clock_root_sel == `OSM_SRC_INT_FAST);
  pll_swap_c:  cover property ($changed(o_core_clock_root_sel) &&
                               o_core_clock_root_sel == `OSM_SRC_PLL);
  slow_fail_c: cover property (sfail);
  rdy_irq_c:   cover property ($rose(o_ready_irq));

endmodule
`default_nettype wire

// >>> osm_clock_ctrl_tb.sv
// self-checking bench for the oscillator select and clock monitor
`include "osm_cfg.svh"
`default_nettype none
module osm_clock_ctrl_tb
  import osm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_pll_lock = 1'b1;
  logic i_battery_mode = 1'b0, i_wdg_run = 1'b0, err;
  logic fast_run = 1'b1, slow_run = 1'b1;
  wire logic i_fast_osc_input_pin, i_slow_osc_input_pin;
  osm_apb_req_t i_apb = '0;
  logic o_pready, o_pslverr, o_internal_fast_osc_en, o_internal_lp_osc_en,
    o_internal_slow_osc_en, o_fast_ext_enable, o_fast_ext_bypass,
    o_fast_ext_gate, o_slow_ext_enable, o_slow_ext_bypass, o_slow_ext_gate,
    o_pll_enable, o_pll_src, o_core_clock_root_gate, o_timer_break,
    o_fast_ext_fail_irq, o_ready_irq, o_slow_fail_wake;
  logic [1:0]  o_slow_ext_drive_level, o_calendar_clock_select;
  logic [1:0]  o_core_clock_root_sel;
  logic [31:0] o_prdata, rd;
  logic [31:0] roots [3] = '{32'h10B, 32'h36B, 32'h2EB};
  logic [1:0]  drv [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
  int          failures = 0, n_checks = 0, cyc = 0;
  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  osm_osc_src i_osm_osc_src
    (.i_run(fast_run), .o_clk(i_fast_osc_input_pin));
  osm_osc_src #(.HALF_NS(500)) i_osm_osc_src_slow
    (.i_run(slow_run), .o_clk(i_slow_osc_input_pin));
  osm_clock_ctrl #(.FAST_START_EDGES(12'h004), .SLOW_START_EDGES(12'h004),
    .SLOW_FAIL_CYC(16'h0050), .GATE_CYC(4'h2)) i_osm_clock_ctrl (
    .i_clk, .i_arst_n, .i_apb, .o_pready, .o_prdata, .o_pslverr,
    .i_fast_osc_input_pin, .i_slow_osc_input_pin, .i_pll_lock,
    .i_battery_mode, .i_wdg_run, .o_internal_fast_osc_en,
    .o_internal_lp_osc_en, .o_internal_slow_osc_en, .o_fast_ext_enable,
    .o_fast_ext_bypass, .o_fast_ext_gate, .o_slow_ext_enable,
    .o_slow_ext_bypass, .o_slow_ext_drive_level, .o_slow_ext_gate,
    .o_calendar_clock_select, .o_pll_enable, .o_pll_src,
    .o_core_clock_root_sel, .o_core_clock_root_gate, .o_timer_break,
    .o_fast_ext_fail_irq, .o_ready_irq, .o_slow_fail_wake);
  // ----------------------------------------------------------------
  // clock, timeout and tasks
  // ----------------------------------------------------------------
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    i_apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_clk);
    i_apb.penable <= 1'b1;
    do
      @(posedge i_clk);
    while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_apb <= '0;
  endtask
  task automatic poll(input logic [11:0] a, input logic [31:0] m, v,
                      input string what);
    for (int n = 0; n < 150; n++) begin
      apb(1'b0, a, '0);
      if ((rd & m) === v)
        break;
    end
    chk(rd & m, v, what);
  endtask
  task automatic st();
    repeat (3) @(posedge i_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'b1;
    apb(1'b0, `OSM_ADDR_CTRL, '0);
    chk(rd, 32'h1, "ctrl reset");
    apb(1'b0, 12'h010, '0);
    chk(err, 1'b1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, `OSM_ADDR_STAT, 32'hFFFF_FFFF);
    poll(`OSM_ADDR_STAT, 32'h3B, 32'h0, "stat read only");
    $display("test reset done");
    apb(1'b1, `OSM_ADDR_CTRL, 32'h0F);
    st();
    chk({o_internal_lp_osc_en, o_internal_slow_osc_en}, 2'h3, "en");
    chk(o_fast_ext_gate, 1'b0, "fast withheld");
    poll(`OSM_ADDR_STAT, 32'h1, 32'h1, "fast ready");
    chk(o_fast_ext_gate, 1'b1, "fast gate");
    apb(1'b1, `OSM_ADDR_CIR, 32'h100);
    st();
    chk(o_ready_irq, 1'b1, "ready irq");
    apb(1'b1, `OSM_ADDR_CIR, 32'h101);
    st();
    chk(o_ready_irq, 1'b0, "ready irq clear");
    foreach (roots[k]) begin
      apb(1'b1, `OSM_ADDR_CTRL, roots[k]);
      poll(`OSM_ADDR_STAT, 32'h30, (roots[k] >> 4) & 32'h30, "root");
      st();
      chk(o_core_clock_root_sel, roots[k][9:8], "root sel");
      chk(o_core_clock_root_gate, 1'b1, "root gate");
    end
    apb(1'b1, `OSM_ADDR_CTRL, 32'h2E3);
    apb(1'b0, `OSM_ADDR_CTRL, '0);
    chk(rd & 32'h8, 32'h8, "clear refused");
    apb(1'b1, `OSM_ADDR_CTRL, 32'h2FB);
    st();
    chk({o_fast_ext_bypass, o_pll_src}, 2'h3, "bypass");
    $display("test fast setup done");
    fast_run <= 1'b0;
    for (int n = 0; n < 200 && o_timer_break !== 1'b1; n++)
      @(posedge i_clk);
    chk(o_timer_break, 1'b1, "break");
    chk({o_fast_ext_enable, o_fast_ext_fail_irq}, 2'h1, "fail");
    chk(o_pll_enable, 1'b0, "pll off");
    @(posedge i_clk);
    chk(o_timer_break, 1'b0, "break pulse");
    poll(`OSM_ADDR_STAT, 32'h30, 32'h0, "fallback");
    chk(o_internal_fast_osc_en, 1'b1, "int fast on");
    st();
    chk(o_core_clock_root_gate, 1'b1, "gate back");
    chk(o_fast_ext_fail_irq, 1'b1, "nmi held");
    apb(1'b1, `OSM_ADDR_CIR, 32'h4);
    st();
    chk(o_fast_ext_fail_irq, 1'b0, "nmi cleared");
    apb(1'b1, `OSM_ADDR_CTRL, 32'h89);
    i_wdg_run <= 1'b1;
    repeat (120) @(posedge i_clk);
    chk(o_internal_slow_osc_en, 1'b1, "watchdog slow osc");
    chk({o_fast_ext_enable, o_fast_ext_fail_irq}, 2'h2, "no start");
    $display("test fast failure done");
    foreach (drv[k]) begin
      apb(1'b1, `OSM_ADDR_BDCR, (32'(drv[k]) << 3) | 32'h1);
      st();
      chk(o_slow_ext_drive_level, drv[k], "drive pin");
      apb(1'b0, `OSM_ADDR_BDCR, '0);
      chk((rd >> 3) & 32'h3, 32'(drv[k]), "drive reg");
    end
    chk({o_slow_ext_enable, o_slow_ext_gate}, 2'h2, "slow held");
    poll(`OSM_ADDR_BDCR, 32'h2, 32'h2, "slow ready");
    chk(o_slow_ext_gate, 1'b1, "slow gate");
    apb(1'b1, `OSM_ADDR_CIR, 32'h200);
    st();
    chk(o_ready_irq, 1'b1, "slow irq");
    // monitor armed after ready and source select
    apb(1'b1, `OSM_ADDR_BDCR, 32'h11D);
    apb(1'b1, `OSM_ADDR_BDCR, 32'h51D);
    st();
    chk(o_slow_ext_bypass, 1'b1, "slow bypass");
    chk(o_calendar_clock_select, 2'h1, "calendar select");
    slow_run <= 1'b0;
    for (int n = 0; n < 300 && o_slow_fail_wake !== 1'b1; n++)
      @(posedge i_clk);
    chk(o_slow_fail_wake, 1'b1, "wake");
    apb(1'b0, `OSM_ADDR_BDCR, '0);
    chk(rd & 32'hC00, 32'hC00, "monitor kept");
    i_battery_mode <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk(o_slow_fail_wake, 1'b0, "battery no wake");
    $display("test slow done");
    results();
  end
endmodule
`default_nettype wire

// >>> osm_osc_src.sv
// behavioural external crystal or user clock source
`default_nettype none
module osm_osc_src #(
  parameter int HALF_NS = 50 // half period in ns
)(
  input  wire logic i_run, // source running
  output var logic  o_clk  // clock towards the pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // clock generation
  // ----------------------------------------------------------------
  // even duty clock
  initial begin
    o_clk = 1'b0;
    forever begin
      #(HALF_NS);
      // a stopped source holds its level, like a dead crystal
      if (i_run)
        o_clk = ~o_clk;
    end
  end
endmodule
`default_nettype wire

// >>> osm_pkg.sv
// types shared by the oscillator select and clock monitor block
`default_nettype none
package osm_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum {SW_IDLE, SW_GATE, SW_OPEN} osm_sw_t;

  // apb request carried as one bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } osm_apb_req_t;

  // whole register state of the block
  typedef struct packed {
    logic int_fast_en; logic int_lp_en; logic int_slow_en; logic int_slow_on;
    logic fast_en; logic fast_byp; logic pll_en; logic pll_src;
    logic fast_css_en; logic [1:0] root_req; logic [1:0] root_act;
    logic slow_en; logic slow_byp; logic [1:0] drive; logic [1:0] cal_sel;
    logic slow_css_en; logic slow_fail;
    logic fast_rdy_f; logic slow_rdy_f; logic fast_fail_f;
    logic fast_rdy_ie; logic slow_rdy_ie;
    logic [2:0] fsync; logic [2:0] ssync; logic [1:0] pll_sync;
    logic [1:0] bat_sync; logic [1:0] wdg_sync;
    logic [11:0] fast_cnt; logic fast_rdy; logic [11:0] slow_cnt;
    logic slow_rdy; logic [15:0] fwd; logic [15:0] swd;
    osm_sw_t sw; logic [3:0] gcnt; logic gate;
    logic brk; logic rdy_irq; logic wake;
    logic pready; logic [31:0] prdata; logic pslverr;
  } osm_state_t;

endpackage
`default_nettype wire
